/* inc/strap_params.svh */
// Timing counts and field positions for the reset and strap sampling block
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH
`define CLK_PERIOD_NS      50
`define STRAP_DELAY_NS     1500
`define STRAP_DELAY_CYCLES ((`STRAP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_COUNT        8
`define TRIGGER_STRAP_BIT  4
`define STRAP_RESET_VALUE  8'h00
`endif

/* inc/strap_pins_if.sv */
// Strap pin group carried between the sequencer and its pad driver
`timescale 1ns/1ps
`default_nettype none
interface strap_pins_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] drive;
	logic             enable;
	modport seq (input level, output drive, output enable);
	modport pad (output level, input drive, input enable);
endinterface : strap_pins_if
`default_nettype wire

/* inc/strap_pkg.sv */
// Types shared by the reset and strap sampling block
package strap_pkg;
	typedef enum logic [1:0] {
		seq_reset,
		seq_wait,
		seq_capture,
		seq_run
	} seq_state_type;
endpackage : strap_pkg

/* rtl/reset_strap_seq.sv */
// Power-on reset sequencer with one-shot strap capture
`timescale 1ns/1ps
`default_nettype none
`include "strap_params.svh"
module reset_strap_seq #(
	parameter int STRAPS       = `STRAP_COUNT,
	parameter int DELAY_CYCLES = `STRAP_DELAY_CYCLES
) (
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic [STRAPS-1:0] strap_level_in,
	input  wire logic [STRAPS-1:0] test_output_in,
	input  wire logic              trigger_output_one_in,
	output logic [STRAPS-1:0]      strap_data_out,
	output logic [STRAPS-1:0]      strap_enable_out,
	output logic [STRAPS-1:0]      test_mode_out,
	output logic                   config_start_out,
	output logic                   ready_out
);
	localparam int CW = $clog2(DELAY_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

	strap_pkg::seq_state_type state_q;
	strap_pkg::seq_state_type state_d;
	logic              sync1_q;
	logic              sync2_q;
	logic [CW-1:0]     count_q;
	logic [CW-1:0]     count_d;
	logic [STRAPS-1:0] mode_q;
	logic              start_q;
	logic [STRAPS-1:0] drive_word;
	wire               delay_done;
	wire               in_run;

	strap_pins_if #(.WIDTH(STRAPS)) pins ();

	// State match, shared by the run, capture and start decodes
	function automatic logic is_state(
		input strap_pkg::seq_state_type cur,
		input strap_pkg::seq_state_type want
	);
		is_state = (cur == want);
	endfunction : is_state

	// Two-flop release synchroniser; reset itself forces everything idle
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= 1'b1;
			sync2_q <= sync1_q;
		end
	end

	assign delay_done = (count_q == LAST);
	assign in_run     = is_state(state_q, strap_pkg::seq_run);

	// Sequence: wait for release, count the delay, capture once, then run
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			strap_pkg::seq_reset: begin
				if (sync2_q) begin
					state_d = strap_pkg::seq_wait;
				end
			end
			strap_pkg::seq_wait: begin
				count_d = count_q + CW'(1);
				if (delay_done) begin
					state_d = strap_pkg::seq_capture;
				end
			end
			strap_pkg::seq_capture: begin
				state_d = strap_pkg::seq_run;
			end
			strap_pkg::seq_run: begin
				state_d = strap_pkg::seq_run; // Only reset leaves run
			end
			default: begin
				state_d = strap_pkg::seq_reset;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= strap_pkg::seq_reset;
			count_q <= '0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	// Capture straps in the single capture cycle; pulldowns make open pins zero
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode_q <= STRAPS'(`STRAP_RESET_VALUE);
		end else if (is_state(state_q, strap_pkg::seq_capture)) begin
			mode_q <= pins.level;
		end
	end

	// One-cycle start pulse when the release has been seen
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			start_q <= 1'b0;
		end else begin
			start_q <= is_state(state_q, strap_pkg::seq_reset) && sync2_q;
		end
	end

	// Output word: test outputs with pin 4 replaced by the trigger
	always_comb begin
		drive_word = test_output_in;
		drive_word[`TRIGGER_STRAP_BIT] = trigger_output_one_in;
	end

	// Pins are released only in run, so capture never sees our own drive
	assign pins.drive  = in_run ? drive_word : '0;
	assign pins.enable = in_run;

	strap_pad_driver #(.WIDTH(STRAPS)) pad_i (
		.pins           (pins.pad),
		.pad_level_in   (strap_level_in),
		.pad_data_out   (strap_data_out),
		.pad_enable_out (strap_enable_out)
	);

	assign test_mode_out    = mode_q;
	assign config_start_out = start_q;
	assign ready_out        = in_run;
endmodule : reset_strap_seq
`default_nettype wire

/* rtl/strap_pad_driver.sv */
// Pad-side splitting of the strap pins into input, output and enable
`timescale 1ns/1ps
`default_nettype none
module strap_pad_driver #(
	parameter int WIDTH = 8
) (
	strap_pins_if.pad         pins,
	input  wire logic [WIDTH-1:0] pad_level_in,
	output logic [WIDTH-1:0]      pad_data_out,
	output logic [WIDTH-1:0]      pad_enable_out
);
	// Enable is one bit for the whole group, fanned out per pin
	assign pins.level     = pad_level_in;
	assign pad_data_out   = pins.enable ? pins.drive : '0;
	assign pad_enable_out = {WIDTH{pins.enable}};
endmodule : strap_pad_driver
`default_nettype wire

/* verification/power_manager_model.sv */
// Power manager and strap board model on the far side
`timescale 1ns/1ps
`default_nettype none
module power_manager_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] data_in,
	input  wire logic [7:0] enable_in,
	output logic            rst_b_out,
	output logic [7:0]      level_out
);
	logic [7:0] ext_q = 8'h00; // Open pins read low through pulldown
	logic       scan_port_reset_n = 1'b0; // Scan port reset tied low on the board
	initial rst_b_out = 1'b0;
	// Undriven pins show the board level, never stale device data
	assign level_out = (enable_in & data_in) | (~enable_in & ext_q);
	// Reset held until supplies settle, then one clean release
	task automatic power_cycle(input int n, input logic [7:0] p);
		@(posedge clk_in) rst_b_out <= 1'b0;
		ext_q <= p;
		repeat (n) @(posedge clk_in);
		rst_b_out <= 1'b1;
	endtask : power_cycle
endmodule : power_manager_model
`default_nettype wire

/* verification/reset_and_test_strap_sampling_tb_top.sv */
// Self-checking bench for the reset and strap sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_and_test_strap_sampling_tb_top;
	logic       clk_in = 1'b0;
	logic       rst_b_in, start, ready, trig = 1'b0;
	logic [7:0] lvl, dat, en, mode, tout = 8'h00;
	int         n_errors = 0, tests_run = 0;
	always #25 clk_in = ~clk_in;
	power_manager_model PM (.clk_in(clk_in), .data_in(dat), .enable_in(en),
		.rst_b_out(rst_b_in), .level_out(lvl));
	reset_strap_seq DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .strap_level_in(lvl),
		.test_output_in(tout), .trigger_output_one_in(trig), .strap_data_out(dat),
		.strap_enable_out(en), .test_mode_out(mode), .config_start_out(start), .ready_out(ready));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test
	// Reset drop from reset, run or wait (capture is never hit), straps set, count to run, then disturb
	task automatic t_capture(input logic [7:0] p);
		int c;
		int s;
		c = 0;
		s = 0;
		fork
			PM.power_cycle(6, p);
			begin @(posedge clk_in); #1;
				check(en, 8'h00);
				check({ready, mode[6:0]}, 8'h00);
			end
		join
		while (ready !== 1'b1 && c < 100) begin
			@(posedge clk_in);
			c++;
			#1;
			if (start === 1'b1) s++;
		end
		check(8'(c), 8'h22);
		check(8'(s), 8'h01);
		check(mode, p);
		check(en, 8'hff);
		@(posedge clk_in) begin PM.ext_q <= ~p; tout <= ~tout; trig <= ~trig; end
		@(posedge clk_in); #1;
		check(mode, p);
		check(dat, {tout[7:5], trig, tout[3:0]});
	endtask : t_capture
	initial begin
		t_capture(8'h00);
		t_capture(8'ha5);
		PM.power_cycle(2, 8'hff);
		repeat (20) @(posedge clk_in);
		t_capture(8'h5a);
		stop_test;
	end
	// Hang guard: whole run is under ten microseconds
	initial begin
		#200us;
		n_errors++;
		stop_test;
	end
endmodule : reset_and_test_strap_sampling_tb_top
`default_nettype wire

/* verification/seq_checker_assertions.sv */
// Port checker for the reset and strap sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_checker #(
	parameter int STRAPS       = 8,
	parameter int DELAY_CYCLES = 30
) (
	input wire logic              clk_in,
	input wire logic              rst_b_in,
	input wire logic [STRAPS-1:0] strap_level_in,
	input wire logic [STRAPS-1:0] test_output_in,
	input wire logic              trigger_output_one_in,
	input wire logic [STRAPS-1:0] strap_data_out,
	input wire logic [STRAPS-1:0] strap_enable_out,
	input wire logic [STRAPS-1:0] test_mode_out,
	input wire logic              config_start_out,
	input wire logic              ready_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// Start pulse, then the counted wait, then run
	sequence s_run_up;
		##DELAY_CYCLES !ready_out ##1 ready_out;
	endsequence
	AST_START_ONCE: assert property (config_start_out |=> !config_start_out)
		else $error("start pulse too long");
	AST_DELAY: assert property (config_start_out |-> s_run_up)
		else $error("capture delay wrong");
	AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_b_in |->
		strap_enable_out == '0 && !ready_out && test_mode_out == '0) else $error("active in reset");
	AST_IDLE: assert property (!ready_out |-> strap_enable_out == '0 && strap_data_out == '0)
		else $error("pins driven before run");
	AST_CAPTURE: assert property ($rose(ready_out) |-> test_mode_out == $past(strap_level_in))
		else $error("wrong strap word");
	AST_HOLD: assert property (ready_out |=> ready_out && $stable(test_mode_out))
		else $error("run state lost");
	AST_DRIVE: assert property (ready_out |-> strap_enable_out == '1)
		else $error("straps not driven");
	AST_TRIG: assert property (ready_out |-> strap_data_out[4] == trigger_output_one_in)
		else $error("trigger not on pin 4");
endmodule : seq_checker
bind reset_strap_seq seq_checker #(.STRAPS(STRAPS), .DELAY_CYCLES(DELAY_CYCLES)) CHK (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .strap_level_in(strap_level_in),
	.test_output_in(test_output_in), .trigger_output_one_in(trigger_output_one_in),
	.strap_data_out(strap_data_out), .strap_enable_out(strap_enable_out),
	.test_mode_out(test_mode_out), .config_start_out(config_start_out), .ready_out(ready_out));
`default_nettype wire
